// ===== adc_seq_pkg.sv
// Constants for the converter frame sequencer
// Operation
// R1: Host pulses frame sync, which drives convert-start, one clock before each word.
// R2: Continuous conversion uses burst mode with 16-bit words per frame.
// R3: Host empties receive word before the next frame begins.
// R4: Power-down uses 8-bit words so convert-start rises before conversion ends.
// R5: Convert-start idles high in power-down until a wake-up frame.
// R6: Transmit-pin drive sends word 0001 hex for continuous conversion.
// R7: Transmit-pin drive sends word 00FF hex to force power-down.
// R8: Continuous: convert-start high one clock during previous word's last bit.
// R9: Continuous mode uses early framing, active-high frame sync.
// R10: Single conversion: convert-start low for whole conversion, late active-low framing.
// R11: Continuous frame sync may run independent of transmit writes.
// R12: Internal clocks: transmit sync and clock feed receiver and converter.
// R13: External clock: one convert signal and one clock feed both ends.
// R14: External clock: port accepts outside receive clock and sync, 16-bit burst.
// R15: Convert-start fall holds input, starts conversion, drives output low.
// R16: Frame is three zeros, ten result bits, two sub-bits, trailing zero. Code uses four leading zeros and no trailing zero.
// R17: Convert-start rising between 14th and 16th rising clock keeps continuous conversion.
// R18: Rising between 3rd and 14th edge enters partial, then full power-down.
// R19: Result is taken by dropping leading zeros, sub-bits and trailing bit. Code drops four leading bits and the sub-bits; there is no trailing bit.
// R20: Each output bit is sampled on the rising edge after it changed.
package adc_seq_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_PERIOD_NS = 400;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] PD_BITS = 5'h08;
  localparam logic [4:0] LAST_LOW_EDGE = 5'h0F;
  localparam int RESULT_LSB = 2;
  localparam int RESULT_W = 10;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_OVR_BIT = 2;
  localparam int ST_PD_LSB = 3;
  localparam int DATA_SUB_LSB = 10;
  localparam int DATA_RAW_LSB = 16;
  typedef enum logic [1:0] {
    OP_SINGLE = 2'h0,
    OP_CONT = 2'h1,
    OP_PDOWN = 2'h2
  } op_t;
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_PARTIAL = 2'h1;
  localparam logic [1:0] PD_FULL = 2'h2;
endpackage

// ===== adc_frame_sequencer.sv
// Host sequencer: makes serial clock and convert-start, gathers frames
`timescale 1ns/10ps
module adc_frame_sequencer #(
  parameter int HALF_CYC = adc_seq_pkg::SCLK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sclk_o,
  output logic convert_start_n_o,
  input wire logic serial_data_i
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

  state_t state_q, state_d;
  logic [7:0] div_q, div_d;
  logic sclk_q, sclk_d;
  logic cnv_n_q, cnv_n_d;
  logic [4:0] edge_q, edge_d;
  logic [15:0] shift_q, shift_d;
  logic [15:0] data_q, data_d;
  logic valid_q, valid_d;
  logic ovr_q, ovr_d;
  logic [1:0] pd_q, pd_d;
  logic [1:0] fop_q, fop_d;
  logic [1:0] op_q, op_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic din_meta_q, din_q;
  logic tick, rise, fall, word_done;
  logic take, wr_ctrl, go, rd_data, rd_status;

  // Output pin crosses domains; second flop is the only reader of the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_meta_q <= 1'b0;
      din_q <= 1'b0;
    end else begin
      din_meta_q <= serial_data_i;
      din_q <= din_meta_q;
    end
  end

  // Bus: request taken the edge ack is sampled high
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    take = wb_cyc_i & wb_stb_i & ack_q;
    wr_ctrl = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == adc_seq_pkg::CTRL_OFS);
    go = wr_ctrl & wb_dat_i[adc_seq_pkg::CTRL_GO_BIT];
    rd_data = take & ~wb_we_i & (wb_adr_i == adc_seq_pkg::DATA_OFS);
    rd_status = take & ~wb_we_i & (wb_adr_i == adc_seq_pkg::STATUS_OFS);
    op_d = op_q;
    if (wr_ctrl) begin
      op_d = wb_dat_i[adc_seq_pkg::CTRL_OP_LSB +: 2];
    end
    rdat_d = 32'h0000_0000;
    unique case (wb_adr_i)
      adc_seq_pkg::CTRL_OFS: begin
        rdat_d[adc_seq_pkg::CTRL_OP_LSB +: 2] = op_q;
      end
      adc_seq_pkg::STATUS_OFS: begin
        rdat_d[adc_seq_pkg::ST_BUSY_BIT] = (state_q == ST_RUN);
        rdat_d[adc_seq_pkg::ST_VALID_BIT] = valid_q;
        rdat_d[adc_seq_pkg::ST_OVR_BIT] = ovr_q;
        rdat_d[adc_seq_pkg::ST_PD_LSB +: 2] = pd_q;
      end
      adc_seq_pkg::DATA_OFS: begin
        // R19 result extraction
        rdat_d[adc_seq_pkg::RESULT_W-1:0] =
          data_q[adc_seq_pkg::RESULT_LSB +: adc_seq_pkg::RESULT_W];
        rdat_d[adc_seq_pkg::DATA_SUB_LSB +: 2] = data_q[1:0];
        rdat_d[adc_seq_pkg::DATA_RAW_LSB +: 16] = data_q;
      end
      default: begin
        rdat_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      op_q <= adc_seq_pkg::OP_RESET;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      op_q <= op_d;
    end
  end

  // Frame engine
  always_comb begin
    state_d = state_q;
    div_d = div_q;
    sclk_d = sclk_q;
    cnv_n_d = cnv_n_q;
    edge_d = edge_q;
    shift_d = shift_q;
    data_d = data_q;
    valid_d = valid_q;
    ovr_d = ovr_q;
    pd_d = pd_q;
    fop_d = fop_q;
    word_done = 1'b0;
    tick = (div_q == 8'(HALF_CYC - 1));
    rise = (state_q == ST_RUN) & tick & ~sclk_q;
    fall = (state_q == ST_RUN) & tick & sclk_q;
    // R12 R13 one clock drives pin and receiver
    if (state_q == ST_RUN) begin
      div_d = tick ? 8'h00 : div_q + 8'h01;
      if (tick) begin
        sclk_d = ~sclk_q;
      end
    end
    if (rise) begin
      edge_d = edge_q + 5'h01;
      // R20 synced level is the bit set by the previous edge
      shift_d = {shift_q[14:0], din_q};
      // R2 R14 sixteen-bit word closes on the 16th rising edge
      if (edge_q == adc_seq_pkg::LAST_LOW_EDGE && fop_q != adc_seq_pkg::OP_PDOWN) begin
        word_done = 1'b1;
      end
    end
    if (fall) begin
      unique case (fop_q)
        adc_seq_pkg::OP_PDOWN: begin
          // R4 R7 R18 release after 8th edge, well before the 14th
          if (edge_q == adc_seq_pkg::PD_BITS) begin
            cnv_n_d = 1'b1;
            state_d = ST_IDLE;
            pd_d = (pd_q == adc_seq_pkg::PD_NONE) ? adc_seq_pkg::PD_PARTIAL
                                                  : adc_seq_pkg::PD_FULL;
          end
        end
        adc_seq_pkg::OP_CONT: begin
          // R6 R8 R9 R17 one clock high spanning the 16th rising edge
          if (edge_q == adc_seq_pkg::LAST_LOW_EDGE) begin
            cnv_n_d = 1'b1;
          end else if (edge_q == adc_seq_pkg::FRAME_BITS) begin
            edge_d = 5'h00;
            // R1 R11 next frame starts without software help
            if (op_q == adc_seq_pkg::OP_CONT) begin
              cnv_n_d = 1'b0;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          // R10 low through the 16th falling edge
          if (edge_q == adc_seq_pkg::FRAME_BITS) begin
            cnv_n_d = 1'b1;
            state_d = ST_IDLE;
          end
        end
      endcase
    end
    // R3 unread word is flagged; new data and set win over a clear
    if (rd_status) begin
      ovr_d = 1'b0;
    end
    if (rd_data) begin
      valid_d = 1'b0;
    end
    if (word_done) begin
      data_d = shift_d;
      valid_d = 1'b1;
      pd_d = adc_seq_pkg::PD_NONE;
      if (valid_q & ~rd_data) begin
        ovr_d = 1'b1;
      end
    end
    // R15 R5 convert-start falls from idle only on a deliberate start
    if (state_q == ST_IDLE && go) begin
      state_d = ST_RUN;
      cnv_n_d = 1'b0;
      div_d = 8'h00;
      sclk_d = 1'b0;
      edge_d = 5'h00;
      fop_d = wb_dat_i[adc_seq_pkg::CTRL_OP_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      div_q <= 8'h00;
      sclk_q <= 1'b0;
      cnv_n_q <= 1'b1;
      edge_q <= 5'h00;
      shift_q <= 16'h0000;
      data_q <= 16'h0000;
      valid_q <= 1'b0;
      ovr_q <= 1'b0;
      pd_q <= adc_seq_pkg::PD_NONE;
      fop_q <= adc_seq_pkg::OP_RESET;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      cnv_n_q <= cnv_n_d;
      edge_q <= edge_d;
      shift_q <= shift_d;
      data_q <= data_d;
      valid_q <= valid_d;
      ovr_q <= ovr_d;
      pd_q <= pd_d;
      fop_q <= fop_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign sclk_o = sclk_q;
  assign convert_start_n_o = cnv_n_q;
endmodule

// ===== adc_conv_model.sv
// Converter model: one 16-bit serial frame per convert-start
`timescale 1ns/10ps
module adc_conv_model (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [11:0] code_i,
  output logic dout_o,
  output logic [1:0] pd_o
);
  logic [15:0] sr_q = 16'h0000;
  logic act_q = 1'b0;
  int n_q = 0;
  always @(negedge cs_n_i) begin
    sr_q = {4'h0, code_i};
    act_q = 1'b1;
    n_q = 0;
  end
  always @(posedge sclk_i) begin
    sr_q = sr_q << 1;
    n_q = n_q + 1;
  end
  always @(posedge cs_n_i) begin
    pd_o = (n_q >= 3 && n_q < 14) ? ((pd_o == 2'h1) ? 2'h2 : 2'h1) : 2'h0;
    act_q = (n_q == 14 || n_q == 15);
  end
  // Released line flips, so a stale level is never read as data
  assign dout_o = act_q ? sr_q[15] : ~sr_q[15];
endmodule

// ===== adc_seq_checker.sv
// Checker on the sequencer's bus handshake and serial pins
`timescale 1ns/10ps
module adc_seq_checker #(
  parameter int HALF_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sclk_o,
  input wire logic convert_start_n_o
);
  logic sc_q;
  logic cs_q;
  logic fall;
  logic [4:0] rc_q;
  int lv_q;
  int hi_q;
  assign fall = cs_q && !convert_start_n_o;
  always_ff @(posedge clk_i) begin
    sc_q <= sclk_o;
    cs_q <= convert_start_n_o;
    hi_q <= convert_start_n_o ? hi_q + 1 : 0;
    lv_q <= (sclk_o != sc_q || fall) ? 1 : lv_q + 1;
    rc_q <= (rst_i || fall) ? 5'h00 : rc_q + 5'(sclk_o && !sc_q);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property ($rose(wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  a_ack_needs_req: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack without request");
  a_sclk_half: assert property ($changed(sclk_o) |-> lv_q == HALF_CYC)
    else $error("sclk half period");
  a_release_point: assert property ($rose(convert_start_n_o) |->
    rc_q inside {5'h08, 5'h0f, 5'h10}) else $error("convert_start_n release point");
  a_high_last_bit: assert property ($rose(sclk_o) && convert_start_n_o |-> rc_q == 5'h0f)
    else $error("sclk rise while convert_start_n high");
  a_rise_on_fall: assert property ($rose(convert_start_n_o) |-> $fell(sclk_o))
    else $error("convert_start_n rise off sclk fall");
  a_start_clk_low: assert property ($fell(convert_start_n_o) |-> !sclk_o)
    else $error("convert_start_n fall with sclk high");
  a_pulse_period: assert property ($fell(convert_start_n_o) && $fell(sclk_o) |->
    hi_q == 2 * HALF_CYC) else $error("convert_start_n pulse length");
endmodule
bind adc_frame_sequencer adc_seq_checker #(.HALF_CYC(HALF_CYC)) i_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sclk_o(sclk_o),
  .convert_start_n_o(convert_start_n_o));

// ===== testbench.sv
// Self-checking bench for the converter frame sequencer
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  localparam logic [3:0] CT = adc_seq_pkg::CTRL_OFS;
  localparam logic [3:0] ST = adc_seq_pkg::STATUS_OFS;
  localparam logic [3:0] DA = adc_seq_pkg::DATA_OFS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] wsel = 4'hf;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] r;
  logic ack;
  logic sclk;
  logic cs_n;
  logic dout;
  logic [1:0] pd;
  logic [11:0] code = 12'hfff;
  logic [11:0] tbl[16];
  logic [3:0] fr = 4'h0;
  logic [11:0] exp_q[$];
  int compares = 0;
  int n_mismatch = 0;
  always #25 clk_i = ~clk_i;
  adc_frame_sequencer #(.HALF_CYC(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .sclk_o(sclk), .convert_start_n_o(cs_n),
    .serial_data_i(dout));
  adc_conv_model i_adc (.sclk_i(sclk), .cs_n_i(cs_n), .code_i(code), .dout_o(dout), .pd_o(pd));
  // Each frame start fixes the code its word must carry
  always @(negedge cs_n) begin
    exp_q.push_back(code);
    code <= tbl[fr];
    fr <= fr + 4'h1;
  end
  function automatic logic [31:0] xd(input logic [11:0] c);
    return {4'h0, c, 4'h0, c[1:0], c[11:2]};
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, wsel, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
    r = rd;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 300; n++) begin
      wb(1'b0, ST, 32'h0000_0000);
      if (r[b] === v) return;
    end
    n_mismatch++;
    close_out();
  endtask
  initial begin
    void'($urandom(32'hfdd7));
    foreach (tbl[i])
      tbl[i] = (i % 4 == 1) ? {12{i[3]}} : 12'($urandom);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, unmapped place reads zero
    for (int a = 0; a < 16; a += 4) begin
      wb(1'b0, 4'(a), 32'h0000_0000);
      `CHK("reset read", 32'h0000_0000, r)
    end
    // Masked or misplaced go must not start a frame
    wsel = 4'he;
    wb(1'b1, CT, 32'h0000_0003);
    wsel = 4'hf;
    wb(1'b1, ST, 32'h0000_0001);
    wb(1'b0, CT, 32'h0000_0000);
    `CHK("masked op", 32'h0000_0000, r)
    wb(1'b0, ST, 32'h0000_0000);
    `CHK("no start", 32'h0000_0000, r)
    `CHK("idle pin", 1'b1, cs_n)
    for (int p = 1; p < 3; p++) begin
      wb(1'b1, CT, 32'h0000_0005);
      poll(0, 1'b0);
      `CHK("pd level", 2'(p), r[4:3])
      `CHK("model pd", 2'(p), pd)
      `CHK("pd idle", 1'b1, cs_n)
    end
    exp_q.delete();
    repeat (4) begin
      wb(1'b1, CT, 32'h0000_0001);
      poll(0, 1'b0);
      `CHK("pd cleared", 2'h0, r[4:3])
      wb(1'b0, DA, 32'h0000_0000);
      `CHK("single data", xd(exp_q.pop_front()), r)
      `CHK("idle high", 1'b1, cs_n)
    end
    wb(1'b1, CT, 32'h0000_0003);
    wb(1'b0, CT, 32'h0000_0000);
    `CHK("op readback", 32'(adc_seq_pkg::OP_CONT) << adc_seq_pkg::CTRL_OP_LSB, r)
    repeat (5) begin
      poll(1, 1'b1);
      wb(1'b0, DA, 32'h0000_0000);
      `CHK("cont data", xd(exp_q.pop_front()), r)
    end
    // Two frames unread must flag overrun
    repeat (300) @(posedge clk_i);
    wb(1'b0, ST, 32'h0000_0000);
    `CHK("overrun", 1'b1, r[2])
    wb(1'b1, CT, 32'h0000_0000);
    poll(0, 1'b0);
    wb(1'b0, DA, 32'h0000_0000);
    `CHK("last word", xd(exp_q[$]), r)
    wb(1'b0, ST, 32'h0000_0000);
    `CHK("flags clear", 32'h0000_0000, r)
    `CHK("stop high", 2'b10, {cs_n, sclk})
    close_out();
  end
endmodule
